// >>> fpma_defs.svh
// Purpose: Constants for the program memory access block
// Assumes: 100 MHz core clock
// Notes: Offsets are SFR byte addresses
`ifndef FPMA_DEFS_SVH
`define FPMA_DEFS_SVH
`define FPMA_ADR_CTRL 12'h0FA6
`define FPMA_ADR_UNLOCK 12'h0FA7
`define FPMA_ADR_LATCH 12'h0FF5
`define FPMA_ADR_PTR_LO 12'h0FF6
`define FPMA_ADR_PTR_HI 12'h0FF7
`define FPMA_ADR_PTR_UP 12'h0FF8
`define FPMA_BIT_MSEL 7
`define FPMA_BIT_CSEL 6
`define FPMA_BIT_ERASE 4
`define FPMA_BIT_ERR 3
`define FPMA_BIT_PERMIT 2
`define FPMA_BIT_WR 1
`define FPMA_BIT_RD 0
`define FPMA_KEY_ONE 8'h55
`define FPMA_KEY_TWO 8'hAA
`define FPMA_NOP_WORD 16'h0000
`define FPMA_CLK_PERIOD_NS 10
`define FPMA_ERASE_TIME_US 2000
`define FPMA_ERASE_CYCLES (`FPMA_ERASE_TIME_US * 1000 / `FPMA_CLK_PERIOD_NS)
`define FPMA_PROG_CYCLES (`FPMA_ERASE_TIME_US * 1000 / `FPMA_CLK_PERIOD_NS)
`endif

// >>> fpma_pkg.sv
// Purpose: Types for the program memory access block
// Assumes: Included constants header
// Notes: State is one packed struct
package fpma_pkg;
  typedef enum logic [1:0] {
    FPMA_IDLE = 2'b00,
    FPMA_PROG = 2'b01,
    FPMA_ERASE = 2'b10,
    FPMA_EEWR = 2'b11
  } fpma_state_t;
  typedef enum logic [1:0] {
    FPMA_PTR_KEEP = 2'b00,
    FPMA_PTR_POSTINC = 2'b01,
    FPMA_PTR_POSTDEC = 2'b10,
    FPMA_PTR_PREINC = 2'b11
  } fpma_ptr_mode_t;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fpma_sfr_t;
  typedef struct packed {
    logic rd;
    logic wr;
    fpma_ptr_mode_t mode;
  } fpma_tbl_t;
  typedef struct packed {
    fpma_state_t state;
    logic [17:0] cnt;
    logic mem_sel;
    logic cfg_sel;
    logic erase_en;
    logic err;
    logic permit;
    logic wr_bit;
    logic [1:0] unlock;
    logic [21:0] ptr;
    logic [7:0] latch;
    logic [7:0][7:0] hold;
    logic rd_pend;
    logic rd_hi;
    logic [21:0] fl_addr;
    logic fl_prog;
    logic fl_erase;
    logic fl_cfg;
    logic halt;
    logic ee_read;
    logic ee_write;
    logic done_flag;
    logic [7:0] rdata;
    logic [15:0] fetch_word;
  } fpma_regs_t;
endpackage

// >>> fpma_access.sv
// Purpose: Table read/write and self-timed erase/program control
// Assumes: Core drives SFR and table strobes synchronously, one cycle each
// Notes: ARST_N_IN is power-up reset; WARM_RESET_IN is pin or watchdog reset
`timescale 1ns/100ps
`include "fpma_defs.svh"

module fpma_access #(
  parameter int ERASE_CYCLES = `FPMA_ERASE_CYCLES,
  parameter int PROG_CYCLES = `FPMA_PROG_CYCLES
) (
  input wire logic CLOCK_IN,
  input wire logic ARST_N_IN,
  input wire logic WARM_RESET_IN,
  input wire fpma_pkg::fpma_sfr_t SFR_IN,
  input wire fpma_pkg::fpma_tbl_t TBL_IN,
  input wire logic [15:0] FLASH_RDATA_IN,
  input wire logic EE_DONE_IN,
  input wire logic FLAG_CLR_IN,
  input wire logic [15:0] FETCH_WORD_IN,
  input wire logic FETCH_LEGAL_IN,
  output logic [7:0] SFR_RDATA_OUT,
  output logic [21:0] FLASH_ADDR_OUT,
  output logic [63:0] FLASH_WDATA_OUT,
  output logic FLASH_PROG_OUT,
  output logic FLASH_ERASE_OUT,
  output logic CFG_ACCESS_OUT,
  output logic FETCH_HALT_OUT,
  output logic [15:0] FETCH_WORD_OUT,
  output logic EE_READ_OUT,
  output logic EE_WRITE_OUT,
  output logic WRITE_DONE_FLAG_OUT
);
  import fpma_pkg::*;

  localparam logic [17:0] ERASE_LEN = 18'(ERASE_CYCLES);
  localparam logic [17:0] PROG_LEN = 18'(PROG_CYCLES);

  fpma_regs_t r_reg;
  fpma_regs_t r_next;
  logic [21:0] ptr_inc;
  logic [21:0] ptr_dec;
  logic [21:0] ptr_eff;
  logic [7:0][7:0] hold_next;
  logic done_evt;

  // Only the low 21 bits step; bit 21 picks the configuration space
  assign ptr_inc = {r_reg.ptr[21], r_reg.ptr[20:0] + 21'h00_0001};
  assign ptr_dec = {r_reg.ptr[21], r_reg.ptr[20:0] - 21'h00_0001};
  assign ptr_eff = (TBL_IN.mode == FPMA_PTR_PREINC) ? ptr_inc : r_reg.ptr;
  assign done_evt = (r_reg.state != FPMA_IDLE) && (
    (r_reg.state == FPMA_EEWR) ? EE_DONE_IN : (r_reg.cnt == 18'h0_0001));

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_hold
      // Any byte address is legal; only the low three bits pick the entry
      always_comb begin
        hold_next[gi] = r_reg.hold[gi];
        if (TBL_IN.wr && !r_reg.halt && ptr_eff[2:0] == 3'(gi)) begin
          hold_next[gi] = r_reg.latch;
        end
      end
    end
  endgenerate

  always_comb begin
    r_next = r_reg;
    r_next.ee_read = 1'b0;
    r_next.hold = hold_next;
    r_next.rd_pend = 1'b0;
    // Invalid opcodes are replaced before the core sees them
    r_next.fetch_word = FETCH_LEGAL_IN ? FETCH_WORD_IN : `FPMA_NOP_WORD;
    if (r_reg.rd_pend) begin
      r_next.latch = r_reg.rd_hi ? FLASH_RDATA_IN[15:8] : FLASH_RDATA_IN[7:0];
    end
    if ((TBL_IN.rd || TBL_IN.wr) && !r_reg.halt) begin
      if (TBL_IN.rd) begin
        r_next.fl_addr = ptr_eff;
        r_next.rd_pend = 1'b1;
        r_next.rd_hi = ptr_eff[0];
      end
      case (TBL_IN.mode)
        FPMA_PTR_POSTINC: r_next.ptr = ptr_inc;
        FPMA_PTR_POSTDEC: r_next.ptr = ptr_dec;
        FPMA_PTR_PREINC: r_next.ptr = ptr_inc;
        default: r_next.ptr = r_reg.ptr;
      endcase
    end
    r_next.rdata = 8'h00;
    if (SFR_IN.rd) begin
      if (SFR_IN.addr == `FPMA_ADR_CTRL) begin
        r_next.rdata = {r_reg.mem_sel, r_reg.cfg_sel, 1'b0, r_reg.erase_en,
                        r_reg.err, r_reg.permit, r_reg.wr_bit, 1'b0};
      end else if (SFR_IN.addr == `FPMA_ADR_LATCH) begin
        r_next.rdata = r_reg.latch;
      end else if (SFR_IN.addr == `FPMA_ADR_PTR_LO) begin
        r_next.rdata = r_reg.ptr[7:0];
      end else if (SFR_IN.addr == `FPMA_ADR_PTR_HI) begin
        r_next.rdata = r_reg.ptr[15:8];
      end else if (SFR_IN.addr == `FPMA_ADR_PTR_UP) begin
        r_next.rdata = {2'b00, r_reg.ptr[21:16]};
      end else begin
        r_next.rdata = 8'h00;
      end
    end
    if (SFR_IN.wr) begin
      r_next.unlock = 2'd0;
      if (SFR_IN.addr == `FPMA_ADR_CTRL) begin
        r_next.mem_sel = SFR_IN.wdata[`FPMA_BIT_MSEL];
        r_next.cfg_sel = SFR_IN.wdata[`FPMA_BIT_CSEL];
        r_next.erase_en = SFR_IN.wdata[`FPMA_BIT_ERASE];
        r_next.err = SFR_IN.wdata[`FPMA_BIT_ERR];
        r_next.permit = SFR_IN.wdata[`FPMA_BIT_PERMIT];
        // Read start: one-cycle EEPROM read, never for program memory
        if (SFR_IN.wdata[`FPMA_BIT_RD] && !SFR_IN.wdata[`FPMA_BIT_MSEL]
            && !SFR_IN.wdata[`FPMA_BIT_CSEL]) begin
          r_next.ee_read = 1'b1;
        end
        // A start refused while idle leaves the write bit clear, so software can see it
        if (SFR_IN.wdata[`FPMA_BIT_WR] && r_reg.unlock == 2'd2 && r_reg.permit
            && r_reg.state == FPMA_IDLE) begin
          r_next.wr_bit = 1'b1;
          r_next.halt = 1'b1;
          if (SFR_IN.wdata[`FPMA_BIT_CSEL] || SFR_IN.wdata[`FPMA_BIT_MSEL]) begin
            r_next.fl_cfg = SFR_IN.wdata[`FPMA_BIT_CSEL];
            if (SFR_IN.wdata[`FPMA_BIT_ERASE]) begin
              r_next.state = FPMA_ERASE;
              r_next.fl_erase = 1'b1;
              r_next.cnt = ERASE_LEN;
              r_next.fl_addr = {r_reg.ptr[21:6], 6'h00};
            end else begin
              r_next.state = FPMA_PROG;
              r_next.fl_prog = 1'b1;
              r_next.cnt = PROG_LEN;
              r_next.fl_addr = {r_reg.ptr[21:3], 3'h0};
            end
          end else begin
            r_next.state = FPMA_EEWR;
            r_next.ee_write = 1'b1;
            r_next.halt = 1'b0;
          end
        end
      end else if (SFR_IN.addr == `FPMA_ADR_UNLOCK) begin
        if (SFR_IN.wdata == `FPMA_KEY_ONE) begin
          r_next.unlock = 2'd1;
        end else if (SFR_IN.wdata == `FPMA_KEY_TWO && r_reg.unlock == 2'd1) begin
          r_next.unlock = 2'd2;
        end
      end else if (SFR_IN.addr == `FPMA_ADR_LATCH) begin
        r_next.latch = SFR_IN.wdata;
      end else if (SFR_IN.addr == `FPMA_ADR_PTR_LO) begin
        r_next.ptr[7:0] = SFR_IN.wdata;
      end else if (SFR_IN.addr == `FPMA_ADR_PTR_HI) begin
        r_next.ptr[15:8] = SFR_IN.wdata;
      end else if (SFR_IN.addr == `FPMA_ADR_PTR_UP) begin
        r_next.ptr[21:16] = SFR_IN.wdata[5:0];
      end
    end
    // Busy state: the hardware bit overrides whatever software wrote
    if (r_reg.state != FPMA_IDLE) begin
      r_next.wr_bit = 1'b1;
      r_next.cnt = r_reg.cnt - 18'h0_0001;
      if (done_evt) begin
        r_next.state = FPMA_IDLE;
        r_next.wr_bit = 1'b0;
        r_next.halt = 1'b0;
        r_next.fl_prog = 1'b0;
        r_next.fl_erase = 1'b0;
        r_next.ee_write = 1'b0;
        if (r_reg.state == FPMA_ERASE) begin
          r_next.erase_en = 1'b0;
        end
      end
    end else if (!r_next.wr_bit) begin
      r_next.wr_bit = 1'b0;
    end
    // Set wins over a clear in the same cycle
    r_next.done_flag = (r_reg.done_flag && !FLAG_CLR_IN) || done_evt;
    if (WARM_RESET_IN) begin
      // Selects survive so software can trace the failed access
      r_next.err = r_reg.err || (r_reg.state != FPMA_IDLE);
      r_next.state = FPMA_IDLE;
      r_next.wr_bit = 1'b0;
      r_next.halt = 1'b0;
      r_next.fl_prog = 1'b0;
      r_next.fl_erase = 1'b0;
      r_next.ee_write = 1'b0;
      r_next.ee_read = 1'b0;
      r_next.permit = 1'b0;
      r_next.unlock = 2'd0;
      r_next.erase_en = 1'b0;
      r_next.ptr = 22'h00_0000;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign SFR_RDATA_OUT = r_reg.rdata;
  assign FLASH_ADDR_OUT = r_reg.fl_addr;
  assign FLASH_WDATA_OUT = r_reg.hold;
  assign FLASH_PROG_OUT = r_reg.fl_prog;
  assign FLASH_ERASE_OUT = r_reg.fl_erase;
  assign CFG_ACCESS_OUT = r_reg.fl_cfg;
  assign FETCH_HALT_OUT = r_reg.halt;
  assign FETCH_WORD_OUT = r_reg.fetch_word;
  assign EE_READ_OUT = r_reg.ee_read;
  assign EE_WRITE_OUT = r_reg.ee_write;
  assign WRITE_DONE_FLAG_OUT = r_reg.done_flag;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);

  a_halt_follows_start: assert property (
    $rose(r_reg.fl_prog) || $rose(r_reg.fl_erase) |-> FETCH_HALT_OUT)
    else $error("Fetch not halted during flash operation");
  a_halt_ends_done: assert property (
    FETCH_HALT_OUT && done_evt && !WARM_RESET_IN |=> !FETCH_HALT_OUT)
    else $error("Fetch halt not released at timer end");
  a_erase_addr_align: assert property (
    FLASH_ERASE_OUT |-> FLASH_ADDR_OUT[5:0] == 6'h00)
    else $error("Erase address not block aligned");
  a_prog_addr_align: assert property (
    FLASH_PROG_OUT |-> FLASH_ADDR_OUT[2:0] == 3'h0)
    else $error("Program address not block aligned");
  a_start_needs_key: assert property (
    $rose(r_reg.wr_bit) |-> $past(r_reg.unlock) == 2'd2 && $past(r_reg.permit))
    else $error("Write started without unlock and permit");
  a_rd_blocked_prog: assert property (
    EE_READ_OUT |-> !r_reg.mem_sel && !r_reg.cfg_sel)
    else $error("EEPROM read with program memory selected");
  a_rd_one_cycle: assert property (
    EE_READ_OUT |=> !EE_READ_OUT || $past(SFR_IN.wr))
    else $error("EEPROM read strobe too long");
  a_done_sticky: assert property (
    WRITE_DONE_FLAG_OUT && !FLAG_CLR_IN |=> WRITE_DONE_FLAG_OUT)
    else $error("Write done flag lost");
  a_err_on_abort: assert property (
    WARM_RESET_IN && r_reg.state != FPMA_IDLE |=> r_reg.err && !FETCH_HALT_OUT)
    else $error("Aborted operation did not flag error");
  a_sel_kept_reset: assert property (
    WARM_RESET_IN |=> r_reg.mem_sel == $past(r_reg.mem_sel)
      && r_reg.cfg_sel == $past(r_reg.cfg_sel))
    else $error("Select bits changed by warm reset");
  a_unlock_reads_zero: assert property (
    SFR_IN.rd && SFR_IN.addr == `FPMA_ADR_UNLOCK |=> SFR_RDATA_OUT == 8'h00)
    else $error("Unlock port read not zero");
  a_erase_clears_en: assert property (
    r_reg.state == FPMA_ERASE && done_evt |=> !r_reg.erase_en)
    else $error("Erase enable not cleared after erase");
  a_halt_flash_only: assert property (
    FETCH_HALT_OUT |-> FLASH_PROG_OUT || FLASH_ERASE_OUT)
    else $error("Fetch halted without flash operation");
  a_wr_bit_busy: assert property (
    r_reg.state != FPMA_IDLE |-> r_reg.wr_bit)
    else $error("Write bit clear while busy");
  a_wr_bit_done: assert property (
    r_reg.state != FPMA_IDLE && done_evt |=> !r_reg.wr_bit)
    else $error("Write bit not cleared at completion");
  a_fetch_nop_fill: assert property (
    !FETCH_LEGAL_IN |=> FETCH_WORD_OUT == `FPMA_NOP_WORD)
    else $error("Invalid fetch word not replaced");
  a_fetch_word_pass: assert property (
    FETCH_LEGAL_IN |=> FETCH_WORD_OUT == $past(FETCH_WORD_IN))
    else $error("Valid fetch word altered");
  a_hold_byte_load: assert property (
    TBL_IN.wr && !FETCH_HALT_OUT |=> r_reg.hold[$past(ptr_eff[2:0])] == $past(r_reg.latch))
    else $error("Holding byte not loaded from latch");
  a_latch_byte_pick: assert property (
    r_reg.rd_pend && !SFR_IN.wr |=> r_reg.latch == ($past(FLASH_ADDR_OUT[0]) ?
      $past(FLASH_RDATA_IN[15:8]) : $past(FLASH_RDATA_IN[7:0])))
    else $error("Latch byte does not match address bit");
  a_cfg_follows_sel: assert property (
    $rose(FLASH_PROG_OUT) || $rose(FLASH_ERASE_OUT) |-> CFG_ACCESS_OUT == r_reg.cfg_sel)
    else $error("Configuration target differs from select");
  a_eewr_data_sel: assert property (
    $rose(EE_WRITE_OUT) |-> !r_reg.mem_sel && !r_reg.cfg_sel && !FETCH_HALT_OUT)
    else $error("EEPROM write with program memory selected");
  a_ctrl_bit5_zero: assert property (
    SFR_IN.rd && SFR_IN.addr == `FPMA_ADR_CTRL |=> SFR_RDATA_OUT[5] == 1'b0)
    else $error("Unimplemented control bit reads one");
endmodule

// >>> fpma_flash_model.sv
// Purpose: Behavioural flash array and EEPROM seen by the access block
// Assumes: Word at an address is a fixed pattern of the word index
// Notes: EEPROM write ends a fixed few cycles after it starts
`timescale 1ns/100ps
module fpma_flash_model (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [21:0] addr_in,
  input wire logic ee_write_in,
  output logic [15:0] rdata_out,
  output logic ee_done_out
);
  logic [1:0] cnt_reg;
  // Low byte is the word index, high byte its inverse, so a byte swap shows
  assign rdata_out = {~addr_in[8:1], addr_in[8:1]};
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= 2'h0;
      ee_done_out <= 1'b0;
    end else begin
      ee_done_out <= ee_write_in && (cnt_reg == 2'h2);
      cnt_reg <= ee_write_in ? cnt_reg + 2'h1 : 2'h0;
    end
  end
endmodule

// >>> tb_flash_program_memory_access.sv
// Purpose: Self-checking bench for the program memory access block
// Assumes: Shortened timer counts of 20 cycles
// Notes: Registers reached through the block's own SFR strobes
`timescale 1ns/100ps
`include "fpma_defs.svh"
module tb_flash_program_memory_access;
  import fpma_pkg::*;
  localparam int CYC = 20;
  logic clk;
  logic arst_n;
  logic warm;
  logic flag_clr;
  logic legal;
  logic ee_done;
  logic [15:0] frd;
  logic [15:0] fw_in;
  fpma_sfr_t sfr;
  fpma_tbl_t tbl;
  logic [7:0] rdat;
  logic [21:0] faddr;
  logic [63:0] fwdata;
  logic prog;
  logic erase;
  logic cfg;
  logic halt;
  logic [15:0] fw_out;
  logic ee_rd;
  logic ee_wr;
  logic done;
  logic [7:0] v;
  int err_count;
  int checks_done;
  int ee_reads;
  fpma_access #(.ERASE_CYCLES(CYC), .PROG_CYCLES(CYC)) i_dut (
    .CLOCK_IN(clk), .ARST_N_IN(arst_n), .WARM_RESET_IN(warm), .SFR_IN(sfr),
    .TBL_IN(tbl), .FLASH_RDATA_IN(frd), .EE_DONE_IN(ee_done),
    .FLAG_CLR_IN(flag_clr), .FETCH_WORD_IN(fw_in), .FETCH_LEGAL_IN(legal),
    .SFR_RDATA_OUT(rdat), .FLASH_ADDR_OUT(faddr), .FLASH_WDATA_OUT(fwdata),
    .FLASH_PROG_OUT(prog), .FLASH_ERASE_OUT(erase), .CFG_ACCESS_OUT(cfg),
    .FETCH_HALT_OUT(halt), .FETCH_WORD_OUT(fw_out), .EE_READ_OUT(ee_rd),
    .EE_WRITE_OUT(ee_wr), .WRITE_DONE_FLAG_OUT(done));
  fpma_flash_model i_flash (.clock_in(clk), .arst_n_in(arst_n), .addr_in(faddr),
    .ee_write_in(ee_wr), .rdata_out(frd), .ee_done_out(ee_done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (ee_rd === 1'b1) begin
      ee_reads++;
    end
  end
  task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sfr_wr(input logic [11:0] a, input logic [7:0] d);
    sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick(1);
    sfr.wr = 1'b0;
    // Idle edge so a following call never raises a strobe in the same step
    tick(1);
  endtask
  task automatic sfr_rd(input logic [11:0] a, output logic [7:0] d);
    sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    tick(1);
    d = rdat;
    sfr.rd = 1'b0;
    tick(1);
  endtask
  task automatic tbl_op(input logic r, input logic w, input fpma_ptr_mode_t m);
    tbl = '{rd: r, wr: w, mode: m};
    tick(1);
    tbl = '0;
    tick(2);
  endtask
  task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
    sfr_wr(`FPMA_ADR_PTR_UP, 8'h00);
    sfr_wr(`FPMA_ADR_PTR_HI, hi);
    sfr_wr(`FPMA_ADR_PTR_LO, lo);
  endtask
  task automatic start_op(input logic [7:0] d);
    sfr_wr(`FPMA_ADR_UNLOCK, `FPMA_KEY_ONE);
    sfr_wr(`FPMA_ADR_UNLOCK, `FPMA_KEY_TWO);
    sfr_wr(`FPMA_ADR_CTRL, d);
    tick(1);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < CYC + 10 && halt !== 1'b0; i++) tick(1);
    if (halt !== 1'b0) begin
      err_count++;
      summarize();
    end
  endtask
  initial begin
    err_count = 0;
    checks_done = 0;
    ee_reads = 0;
    arst_n = 1'b0;
    warm = 1'b0;
    flag_clr = 1'b0;
    legal = 1'b1;
    fw_in = 16'h0000;
    sfr = '0;
    tbl = '0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("ctrl_reset", v, 8'h00);
    sfr_wr(`FPMA_ADR_UNLOCK, 8'h5A);
    sfr_rd(`FPMA_ADR_UNLOCK, v);
    chk("unlock_read", v, 8'h00);
    set_ptr(8'h01, 8'h03);
    tbl_op(1'b1, 1'b0, FPMA_PTR_POSTINC);
    sfr_rd(`FPMA_ADR_LATCH, v);
    chk("latch_odd", v, 8'h7E);
    tbl_op(1'b1, 1'b0, FPMA_PTR_POSTINC);
    sfr_rd(`FPMA_ADR_LATCH, v);
    chk("latch_even", v, 8'h82);
    sfr_wr(`FPMA_ADR_LATCH, 8'hC3);
    sfr_rd(`FPMA_ADR_LATCH, v);
    chk("latch_rw", v, 8'hC3);
    tbl_op(1'b0, 1'b1, FPMA_PTR_KEEP);
    chk("hold_byte5", fwdata[47:40], 8'hC3);
    tbl_op(1'b1, 1'b0, FPMA_PTR_PREINC);
    sfr_rd(`FPMA_ADR_LATCH, v);
    chk("latch_preinc", v, 8'h83);
    tbl_op(1'b1, 1'b0, FPMA_PTR_POSTDEC);
    tbl_op(1'b1, 1'b0, FPMA_PTR_KEEP);
    sfr_rd(`FPMA_ADR_LATCH, v);
    chk("latch_postdec", v, 8'h7D);
    sfr_rd(`FPMA_ADR_PTR_LO, v);
    chk("ptr_lo", v, 8'h05);
    sfr_wr(`FPMA_ADR_CTRL, 8'h86);
    tick(1);
    chk("no_unlock", prog, 1'b0);
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("ctrl_refused", v, 8'h84);
    start_op(8'h86);
    chk("prog_on", prog, 1'b1);
    chk("halt_prog", halt, 1'b1);
    chk("prog_addr", faddr, 22'h000100);
    sfr_wr(`FPMA_ADR_CTRL, 8'h84);
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("wr_kept", v[1], 1'b1);
    wait_idle();
    chk("done_set", done, 1'b1);
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("wr_cleared", v, 8'h84);
    flag_clr = 1'b1;
    tick(1);
    flag_clr = 1'b0;
    tick(1);
    chk("done_clr", done, 1'b0);
    // Pointer picked so the erase row and the write block differ
    set_ptr(8'h00, 8'hED);
    start_op(8'h96);
    chk("erase_on", erase, 1'b1);
    chk("erase_addr", faddr, 22'h0000C0);
    tick(CYC - 6);
    chk("erase_stall", halt, 1'b1);
    wait_idle();
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("erase_bit_clr", v, 8'h84);
    start_op(8'hC6);
    chk("cfg_access", cfg, 1'b1);
    warm = 1'b1;
    tick(1);
    warm = 1'b0;
    tick(1);
    chk("abort_halt", halt, 1'b0);
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("abort_ctrl", v, 8'hC8);
    fw_in = 16'h1234;
    legal = 1'b0;
    tick(1);
    chk("fetch_bad", fw_out, `FPMA_NOP_WORD);
    legal = 1'b1;
    tick(1);
    chk("fetch_ok", fw_out, 16'h1234);
    sfr_wr(`FPMA_ADR_CTRL, 8'h81);
    tick(2);
    chk("rd_ignored", ee_reads, 0);
    sfr_wr(`FPMA_ADR_CTRL, 8'h01);
    tick(2);
    chk("rd_once", ee_reads, 1);
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("rd_cleared", v[0], 1'b0);
    sfr_wr(`FPMA_ADR_CTRL, 8'h04);
    flag_clr = 1'b1;
    tick(1);
    flag_clr = 1'b0;
    start_op(8'h06);
    chk("ee_write_on", ee_wr, 1'b1);
    chk("ee_no_halt", halt, 1'b0);
    chk("ee_done_wait", done, 1'b0);
    tick(3);
    chk("ee_write_off", ee_wr, 1'b0);
    chk("ee_done_set", done, 1'b1);
    sfr_rd(`FPMA_ADR_CTRL, v);
    chk("ee_wr_cleared", v, 8'h04);
    summarize();
  end
endmodule
